// File: rtl/radio_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_mode_params.svh"
// Overview of operation
// - After reset the controller holds power-on reset, then enters power down only.
// - Power-up bit low gives power down; registers kept, bus still usable.
// - Power-up bit high moves power down to standby-I.
// - Chip-enable low in TX or RX returns to standby-I.
// - Transmitter role, chip-enable high, empty TX FIFO gives standby-II; upload then select-high write transmits.
// - RX entered only with power-up, primary-receive and chip-enable all high.
// - Valid packet needs address match and CRC; payload goes to vacant slot.
// - Valid packet with full RX FIFO is dropped.
// - RX held until host selects standby-I or power down.
// - Carrier detect rises after 128 us continuous in-channel signal, else low.
// - TX needs power-up, transmitter role, payload, chip-enable high over 10 us.
// - After a packet: CE low standby-I, else next packet or standby-II.
// - With chip-enable high, all TX levels drain and refills keep sending.
// - One chip-enable pulse of at least 10 us sends exactly one packet.
// - Standby to TX or RX takes at most 130 us; TX reaches RX only through standby-I.
// - Air rate bit in radio setup register selects 1 or 2 Mbps.
// - Registers cleared on power loss; host reprograms before TX or RX.
module radio_mode_ctrl (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire radio_mode_pkg::word_t pwdata,
   output radio_mode_pkg::word_t      prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  chip_enable,
   input  wire logic                  rf_present,
   input  wire logic                  rx_pkt_valid,
   input  wire logic                  rx_addr_match,
   input  wire logic                  rx_crc_ok,
   input  wire logic [31:0]           rx_payload,
   output logic                       tx_active,
   output logic                       rx_active,
   output logic                       synth_on,
   output logic                       tx_pkt_start,
   output logic [31:0]                tx_payload,
   output logic                       air_rate_2m
);
   import radio_mode_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      mode_e       mode;
      mode_e       target;
      logic [10:0] timer;
      logic [10:0] ce_cnt;
      logic        ce_long;
      logic        power_up_bit;
      logic        primary_receive_select;
      logic        select_high;
      logic        upload_pending;
      logic [7:0]  radio_setup;
      logic        rx_drop;
      logic [4:0]  por_cnt;
      logic        por_done;
      word_t       prdata;
      logic        pready;
      logic        pslverr;
      logic        tx_active;
      logic        rx_active;
      logic        synth_on;
      logic        tx_pkt_start;
      logic        rd_pending;
   } ctrl_s;
   ctrl_s s_reg;
   ctrl_s s_next;

   logic        tx_wr;
   logic        tx_rd;
   logic [31:0] tx_q;
   logic        tx_empty;
   logic        tx_full;
   logic        rx_wr;
   logic        rx_rd;
   logic [31:0] rx_q;
   logic        rx_empty;
   logic        rx_full;
   logic        cd_flag;
   logic        wr_acc;
   logic        rd_acc;
   logic        rx_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // The access phase is answered in its first cycle, so pready is combinational-free.
   assign wr_acc = psel && penable && pwrite && s_reg.pready;
   assign rd_acc = psel && penable && !pwrite && s_reg.pready;
   assign tx_wr  = wr_acc && (paddr == `OFS_TXFIFO);
   assign rx_rd  = psel && !penable && !pwrite && (paddr == `OFS_RXFIFO);
   assign tx_rd  = (s_next.mode == st_tx) && (s_reg.mode != st_tx || s_reg.timer == '0)
                   && s_next.tx_pkt_start;
   assign rx_ok  = (s_reg.mode == st_rx) && rx_pkt_valid && rx_addr_match && rx_crc_ok;
   assign rx_wr  = rx_ok && !rx_full;

   payload_fifo u_tx_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .flush   (1'b0),
      .wr_en   (tx_wr),
      .wr_data (pwdata),
      .rd_en   (tx_rd),
      .rd_data (tx_q),
      .empty   (tx_empty),
      .full    (tx_full)
   );

   payload_fifo u_rx_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .flush   (1'b0),
      .wr_en   (rx_wr),
      .wr_data (rx_payload),
      .rd_en   (rx_rd),
      .rd_data (rx_q),
      .empty   (rx_empty),
      .full    (rx_full)
   );

   cd_filter u_cd (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (s_reg.mode == st_rx),
      .rf_present (rf_present),
      .cd         (cd_flag)
   );

   function automatic word_t status_word(input ctrl_s s, input logic cd,
                                         input logic [3:0] fl);
      status_word = '0;
      status_word[`ST_MODE_LSB +: 3] = s.mode;
      status_word[`ST_CD]       = cd;
      status_word[`ST_TX_EMPTY] = fl[0];
      status_word[`ST_TX_FULL]  = fl[1];
      status_word[`ST_RX_EMPTY] = fl[2];
      status_word[`ST_RX_FULL]  = fl[3];
      status_word[`ST_RX_DROP]  = s.rx_drop;
      status_word[`ST_POR_DONE] = s.por_done;
   endfunction : status_word

   ////////////////////////////////////////////////////////////////////////////////
   // single sampled machine
   always_comb begin
      logic ce;
      logic tx_req;
      logic rx_req;
      ce = chip_enable;
      tx_req = s_reg.power_up_bit && !s_reg.primary_receive_select && !tx_empty;
      rx_req = s_reg.power_up_bit && s_reg.primary_receive_select && ce;
      s_next = s_reg;
      s_next.tx_pkt_start = 1'b0;
      s_next.pready = psel && !penable;
      s_next.pslverr = 1'b0;
      if (s_reg.timer != '0) begin
         s_next.timer = s_reg.timer - 11'd1;
      end
      if (!ce) begin
         s_next.ce_cnt = '0;
      end else if (s_reg.ce_cnt < 11'(`THCE_CYC)) begin
         s_next.ce_cnt = s_reg.ce_cnt + 11'd1;
      end
      s_next.ce_long = ce && (s_reg.ce_cnt >= 11'(`THCE_CYC - 1));

      // Register writes and read data; unmapped offsets answer with an error.
      if (psel && !penable) begin
         unique case (paddr)
            `OFS_CONTROL: begin
               s_next.prdata = {29'h0, s_reg.select_high, s_reg.primary_receive_select,
                                s_reg.power_up_bit};
            end
            `OFS_STATUS: begin
               s_next.prdata = status_word(s_reg, cd_flag,
                                           {rx_full, rx_empty, tx_full, tx_empty});
            end
            `OFS_TXFIFO: begin
               s_next.prdata = '0;
            end
            `OFS_RXFIFO: begin
               s_next.prdata = '0;
            end
            `OFS_RADIO_SETUP: begin
               s_next.prdata = {24'h0, s_reg.radio_setup};
            end
            default: begin
               s_next.prdata = '0;
               s_next.pslverr = 1'b1;
            end
         endcase
      end
      if (rd_acc && paddr == `OFS_RXFIFO) begin
         s_next.rd_pending = 1'b1;
      end
      if (wr_acc) begin
         unique case (paddr)
            `OFS_CONTROL: begin
               s_next.power_up_bit = pwdata[`CTL_POWER_UP];
               s_next.primary_receive_select = pwdata[`CTL_PRIMARY_RECEIVE_SELECT];
               s_next.select_high = pwdata[`CTL_SELECT_HIGH];
            end
            `OFS_RADIO_SETUP: begin
               s_next.radio_setup = pwdata[7:0];
            end
            `OFS_STATUS: begin
               // Writing one clears the drop flag; a drop in the same cycle wins.
               if (pwdata[`ST_RX_DROP]) begin
                  s_next.rx_drop = 1'b0;
               end
            end
            `OFS_TXFIFO: begin
               s_next.upload_pending = 1'b1;
               s_next.select_high = 1'b0;
            end
            default: begin
            end
         endcase
      end
      if (rx_ok && rx_full) begin
         s_next.rx_drop = 1'b1;
      end

      unique case (s_reg.mode)
         st_por: begin
            if (s_reg.por_cnt == 5'(`POR_CYC - 1)) begin
               s_next.mode = st_power_down;
               s_next.por_done = 1'b1;
            end else begin
               s_next.por_cnt = s_reg.por_cnt + 5'd1;
            end
         end
         st_power_down: begin
            if (s_reg.power_up_bit) begin
               s_next.mode = st_standby1;
            end
         end
         st_standby1: begin
            if (rx_req) begin
               s_next.mode = st_settle;
               s_next.target = st_rx;
               s_next.timer = 11'(`STBY2A_CYC - 1);
            end else if (tx_req && s_reg.ce_long) begin
               s_next.mode = st_settle;
               s_next.target = st_tx;
               s_next.timer = 11'(`STBY2A_CYC - 1);
            end else if (ce && s_reg.ce_long && s_reg.power_up_bit
                         && !s_reg.primary_receive_select && tx_empty) begin
               s_next.mode = st_standby2;
            end
         end
         st_standby2: begin
            if (!ce) begin
               s_next.mode = st_standby1;
            end else if (!tx_empty && s_reg.select_high) begin
               s_next.mode = st_settle;
               s_next.target = st_tx;
               s_next.timer = 11'(`STBY2A_CYC - 1);
               s_next.upload_pending = 1'b0;
            end
         end
         st_settle: begin
            if (s_reg.target == st_rx && !rx_req) begin
               s_next.mode = st_standby1;
               s_next.timer = '0;
            end else if (s_reg.timer == '0) begin
               s_next.mode = s_reg.target;
               if (s_reg.target == st_tx) begin
                  s_next.tx_pkt_start = 1'b1;
                  s_next.timer = 11'(`PKT_CYC - 1);
               end
            end
         end
         st_rx: begin
            if (!ce || !s_reg.primary_receive_select) begin
               s_next.mode = st_standby1;
            end
         end
         st_tx: begin
            if (s_reg.timer == '0) begin
               if (!ce) begin
                  s_next.mode = st_standby1;
               end else if (!tx_empty) begin
                  s_next.tx_pkt_start = 1'b1;
                  s_next.timer = 11'(`PKT_CYC - 1);
               end else begin
                  s_next.mode = st_standby2;
               end
            end
         end
      endcase

      if (!s_reg.power_up_bit && s_reg.mode != st_por) begin
         s_next.mode = st_power_down;
         s_next.tx_pkt_start = 1'b0;
      end
      s_next.tx_active = (s_next.mode == st_tx);
      s_next.rx_active = (s_next.mode == st_rx);
      s_next.synth_on = (s_next.mode == st_tx) || (s_next.mode == st_rx)
                        || (s_next.mode == st_settle);
      if (s_reg.rd_pending) begin
         s_next.rd_pending = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset clears configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Read data of the RX FIFO word arrives from the store's own register.
   assign prdata = (paddr == `OFS_RXFIFO && !pwrite) ? rx_q : s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign tx_active = s_reg.tx_active;
   assign rx_active = s_reg.rx_active;
   assign synth_on = s_reg.synth_on;
   assign tx_pkt_start = s_reg.tx_pkt_start;
   // The payload comes from the store's read register, popped on the packet start edge.
   assign tx_payload = tx_q;
   assign air_rate_2m = s_reg.radio_setup[`SETUP_AIR_RATE];
endmodule : radio_mode_ctrl
`default_nettype wire

// File: rtl/radio_mode_params.svh
`ifndef RADIO_MODE_PARAMS_SVH
`define RADIO_MODE_PARAMS_SVH
// Register byte offsets on the APB bus.
`define OFS_CONTROL      12'h000
`define OFS_STATUS       12'h004
`define OFS_TXFIFO       12'h008
`define OFS_RXFIFO       12'h00C
`define OFS_RADIO_SETUP  12'h010
`define OFS_SETTLE       12'h014
// Control register fields.
`define CTL_POWER_UP     0
`define CTL_PRIMARY_RECEIVE_SELECT      1
`define CTL_SELECT_HIGH  2
// Radio setup register fields.
`define SETUP_AIR_RATE   3
// Status register fields.
`define ST_MODE_LSB      0
`define ST_CD            4
`define ST_TX_EMPTY      5
`define ST_TX_FULL       6
`define ST_RX_EMPTY      7
`define ST_RX_FULL       8
`define ST_RX_DROP       9
`define ST_POR_DONE      10
// Timing, nanoseconds and the 100 ns clock.
`define CLK_PERIOD_NS    100
`define CD_FILTER_NS     128000
`define STBY2A_NS        130000
`define THCE_NS          10000
`define PKT_TIME_NS      50000
`define CD_FILTER_CYC    ((`CD_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STBY2A_CYC       (`STBY2A_NS / `CLK_PERIOD_NS)
`define THCE_CYC         ((`THCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PKT_CYC          (`PKT_TIME_NS / `CLK_PERIOD_NS)
`define POR_CYC          16
`define FIFO_DEPTH       3
`define FIFO_AW          2
`define PAYLOAD_W        32
`endif

// File: rtl/radio_mode_pkg.sv
package radio_mode_pkg;
   typedef enum logic [2:0] {
      st_por,
      st_power_down,
      st_standby1,
      st_standby2,
      st_settle,
      st_rx,
      st_tx
   } mode_e;
   typedef logic [31:0] word_t;
endpackage : radio_mode_pkg

// File: rtl/payload_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_mode_params.svh"
module payload_fifo (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    flush,
   input  wire logic                    wr_en,
   input  wire logic [`PAYLOAD_W-1:0]   wr_data,
   input  wire logic                    rd_en,
   output logic      [`PAYLOAD_W-1:0]   rd_data,
   output logic                         empty,
   output logic                         full
);
   typedef struct packed {
      logic [`FIFO_DEPTH-1:0][`PAYLOAD_W-1:0] mem;
      logic [`FIFO_AW-1:0]                   wp;
      logic [`FIFO_AW-1:0]                   rp;
      logic [`FIFO_AW:0]                     cnt;
      logic [`PAYLOAD_W-1:0]                 rd;
   } fifo_s;
   fifo_s s_reg;
   fifo_s s_next;

   function automatic logic [`FIFO_AW-1:0] wrap_inc(input logic [`FIFO_AW-1:0] p);
      wrap_inc = (p == `FIFO_AW'(`FIFO_DEPTH - 1)) ? '0 : p + `FIFO_AW'(1);
   endfunction : wrap_inc

   // Writes to a full store and reads of an empty one are ignored.
   always_comb begin
      logic do_wr;
      logic do_rd;
      do_wr = wr_en && (s_reg.cnt != (`FIFO_AW+1)'(`FIFO_DEPTH));
      do_rd = rd_en && (s_reg.cnt != '0);
      s_next = s_reg;
      if (do_wr) begin
         s_next.mem[s_reg.wp] = wr_data;
         s_next.wp = wrap_inc(s_reg.wp);
      end
      if (do_rd) begin
         s_next.rd = s_reg.mem[s_reg.rp];
         s_next.rp = wrap_inc(s_reg.rp);
      end
      if (do_wr && !do_rd) begin
         s_next.cnt = s_reg.cnt + (`FIFO_AW+1)'(1);
      end else if (do_rd && !do_wr) begin
         s_next.cnt = s_reg.cnt - (`FIFO_AW+1)'(1);
      end
      if (flush) begin
         s_next.wp = '0;
         s_next.rp = '0;
         s_next.cnt = '0;
      end
   end

   // Contents are lost on reset, as with loss of supply.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rd_data = s_reg.rd;
   assign empty   = (s_reg.cnt == '0);
   assign full    = (s_reg.cnt == (`FIFO_AW+1)'(`FIFO_DEPTH));
endmodule : payload_fifo
`default_nettype wire

// File: rtl/cd_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_mode_params.svh"
module cd_filter (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic rf_present,
   output logic      cd
);
   typedef struct packed {
      logic [10:0] cnt;
      logic        cd;
   } cdf_s;
   cdf_s s_reg;
   cdf_s s_next;

   // A break in the signal or leaving RX restarts the count.
   always_comb begin
      s_next = s_reg;
      if (!enable || !rf_present) begin
         s_next.cnt = '0;
         s_next.cd = 1'b0;
      end else if (s_reg.cnt < 11'(`CD_FILTER_CYC - 1)) begin
         s_next.cnt = s_reg.cnt + 11'd1;
      end else begin
         s_next.cd = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cd = s_reg.cd;
endmodule : cd_filter
`default_nettype wire

// File: bench/radio_mode_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_mode_params.svh"
module radio_mode_chk (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire radio_mode_pkg::word_t pwdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  chip_enable,
   input wire logic                  tx_active,
   input wire logic                  rx_active,
   input wire logic                  synth_on,
   input wire logic                  tx_pkt_start,
   input wire logic                  air_rate_2m
);
   import radio_mode_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [4:0]  por_reg;
   logic [10:0] gap_reg;
   wire         done = psel && penable && pready;
   wire         quiet = !(tx_active || rx_active || synth_on);
   ////////////////////////////////////////////////////////////////////////
   // Counts cycles since reset and since the last packet start, saturating.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_reg <= 5'h00;
         gap_reg <= 11'h7FF;
      end else begin
         por_reg <= (por_reg == 5'h1F) ? por_reg : por_reg + 5'h01;
         gap_reg <= tx_pkt_start ? 11'h000 : (gap_reg == 11'h7FF ? gap_reg : gap_reg + 11'h001);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_por_quiet: assert property (por_reg < 5'h10 |-> quiet)
      else $error("radio active during power-on reset");
   a_pd_quiet: assert property (done && pwrite && paddr == `OFS_CONTROL && !pwdata[0]
      |-> ##[1:3] quiet) else $error("power down did not stop radio");
   a_rx_ce: assert property ($rose(rx_active) |-> $past(chip_enable))
      else $error("receive entered without chip enable");
   a_ce_drop: assert property ($fell(chip_enable) && rx_active |-> ##[0:3] !rx_active)
      else $error("receive kept after chip enable low");
   a_one_dir: assert property (!(tx_active && rx_active))
      else $error("transmit and receive together");
   a_pkt_gap: assert property (tx_pkt_start |-> gap_reg >= `PKT_CYC - 1)
      else $error("packet started before previous one ended");
   a_tx_synth: assert property (tx_pkt_start |-> ##[0:1] (tx_active && synth_on))
      else $error("packet start without active synthesizer");
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("bus answer not in first access cycle");
   a_unmapped: assert property (done |-> pslverr == !(paddr inside {`OFS_CONTROL,
      `OFS_STATUS, `OFS_TXFIFO, `OFS_RXFIFO, `OFS_RADIO_SETUP}))
      else $error("error response wrong for offset");
   a_rate_bit: assert property (done && pwrite && paddr == `OFS_RADIO_SETUP
      |=> air_rate_2m == $past(pwdata[3])) else $error("air rate not following setup");
   c_tx: cover property (tx_pkt_start);
   c_rx: cover property ($rose(rx_active));
   c_err: cover property (done && pslverr);
endmodule : radio_mode_chk
`default_nettype wire

// File: bench/rf_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module rf_link_model (
   input  wire logic        pclk,
   output logic             rf_present,
   output logic             rx_pkt_valid,
   output logic             rx_addr_match,
   output logic             rx_crc_ok,
   output logic [31:0]      rx_payload
);
   ////////////////////////////////////////////////////////////////////////
   // The link starts idle with no carrier on the channel.
   initial begin
      rf_present = 1'b0;
      rx_pkt_valid = 1'b0;
      rx_addr_match = 1'b0;
      rx_crc_ok = 1'b0;
      rx_payload = 32'h0;
   end
   // address and check
   // Qualifiers only hold during the valid pulse; after it they flip so a stale match cannot pass.
   task send(input logic m, input logic c, input logic [31:0] d);
      @(posedge pclk);
      rx_pkt_valid <= 1'b1;
      rx_addr_match <= m;
      rx_crc_ok <= c;
      rx_payload <= d;
      @(posedge pclk);
      rx_pkt_valid <= 1'b0;
      rx_addr_match <= !m;
      rx_crc_ok <= !c;
      rx_payload <= ~d;
   endtask : send
   task carrier(input logic v);
      @(posedge pclk);
      rf_present <= v;
   endtask : carrier
endmodule : rf_link_model
`default_nettype wire

// File: bench/test_radio_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_mode_params.svh"
module test_radio_mode_ctrl;
   import radio_mode_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, chip_enable;
   logic [11:0] paddr;
   word_t       pwdata, prdata;
   logic        pready, pslverr, rf_present, rx_pkt_valid, rx_addr_match, rx_crc_ok;
   logic [31:0] rx_payload, tx_payload, pk [4];
   logic        tx_active, rx_active, synth_on, tx_pkt_start, air_rate_2m;
   logic [64:0] rd_q [$];
   word_t       tx_q [$];
   int          n_mismatch, num_checks, i;
   radio_mode_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .chip_enable, .rf_present, .rx_pkt_valid, .rx_addr_match, .rx_crc_ok,
      .rx_payload, .tx_active, .rx_active, .synth_on, .tx_pkt_start, .tx_payload, .air_rate_2m);
   rf_link_model i_rf (.pclk, .rf_present, .rx_pkt_valid, .rx_addr_match, .rx_crc_ok, .rx_payload);
   // Free running 10 MHz clock.
   always #50 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////
   task summarize;
      if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task cmp_rd(input logic [64:0] e, input logic er, input word_t d);
      num_checks++;
      if ({er, d & e[63:32]} !== {e[64], e[31:0]}) begin
         n_mismatch++;
         $display("BAD %0t %h %h", $time, {er, d & e[63:32]}, {e[64], e[31:0]});
      end
   endtask : cmp_rd
   task cmp_tx(input word_t e, input word_t d);
      num_checks++;
      if (d !== e) begin
         n_mismatch++;
         $display("BAD %0t %h %h", $time, d, e);
      end
   endtask : cmp_tx
   // Reads note {error, mask, value}; d is write data or the expected read value.
   task apb(input logic w, input logic [11:0] a, input word_t d, input word_t m, input logic er);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : word_t'($urandom);
      if (!w) rd_q.push_back({er, m, d});
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         n_mismatch++;
         summarize();
      end
   endtask : apb
   task put;
      word_t d;
      d = $urandom;
      tx_q.push_back(d);
      apb(1'b1, `OFS_TXFIFO, d, 32'h0, 1'b0);
   endtask : put
   // Bounded wait: 0 receive on, 1 receive off, 2 all noted packets started.
   task till(input int s, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(posedge pclk);
         if ((s == 0 && rx_active === 1'b1) || (s == 1 && rx_active === 1'b0)
             || (s == 2 && tx_q.size() == 0)) return;
      end
      n_mismatch++;
      summarize();
   endtask : till
   ////////////////////////////////////////////////////////////////////////
   // Watcher: each finished read or packet start takes the oldest note.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && rd_q.size() > 0)
         cmp_rd(rd_q.pop_front(), pslverr, prdata);
      if (tx_pkt_start === 1'b1) cmp_tx(tx_q.size() > 0 ? tx_q.pop_front() : 'x, tx_payload);
   end
   // Main sequence.
   initial begin
      void'($urandom(80509));
      {pclk, presetn, psel, penable, pwrite, chip_enable} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_STATUS, st_por, 32'h7, 1'b0);
      repeat (20) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h400 | st_power_down, 32'h407, 1'b0);
      apb(1'b0, 12'h018, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1'b1, `OFS_RADIO_SETUP, 32'h8, 32'h0, 1'b0);
      apb(1'b0, `OFS_RADIO_SETUP, 32'h8, 32'h8, 1'b0);
      apb(1'b1, `OFS_CONTROL, 32'h1, 32'h0, 1'b0);
      apb(1'b0, `OFS_STATUS, st_standby1, 32'h7, 1'b0);
      repeat (1500) @(posedge pclk);
      put();
      apb(1'b1, `OFS_CONTROL, 32'h5, 32'h0, 1'b0);
      chip_enable <= 1'b1;
      repeat (`THCE_CYC + 1) @(posedge pclk);
      chip_enable <= 1'b0;
      till(2, 1500);
      repeat (600) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h20 | st_standby1, 32'h27, 1'b0);
      for (i = 0; i < 3; i++) put();
      apb(1'b1, `OFS_TXFIFO, $urandom, 32'h0, 1'b0);
      apb(1'b0, `OFS_STATUS, 32'h40, 32'h40, 1'b0);
      apb(1'b1, `OFS_CONTROL, 32'h5, 32'h0, 1'b0);
      chip_enable <= 1'b1;
      // bounded TX stay, under 400 us.
      till(2, 4000);
      repeat (600) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, st_standby2, 32'h7, 1'b0);
      // select rises long after chip-enable rise.
      put();
      apb(1'b0, `OFS_STATUS, st_standby2, 32'h7, 1'b0);
      apb(1'b1, `OFS_CONTROL, 32'h5, 32'h0, 1'b0);
      till(2, 2000);
      chip_enable <= 1'b0;
      repeat (600) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, st_standby1, 32'h7, 1'b0);
      apb(1'b1, `OFS_CONTROL, 32'h7, 32'h0, 1'b0);
      chip_enable <= 1'b1;
      till(0, `STBY2A_CYC + 10);
      i_rf.carrier(1'b1);
      repeat (1000) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h0, 32'h10, 1'b0);
      repeat (300) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h10, 32'h10, 1'b0);
      i_rf.carrier(1'b0);
      repeat (3) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h0, 32'h10, 1'b0);
      i_rf.send(1'b0, 1'b1, $urandom);
      i_rf.send(1'b1, 1'b0, $urandom);
      for (i = 0; i < 4; i++) begin
         pk[i] = $urandom;
         i_rf.send(1'b1, 1'b1, pk[i]);
      end
      apb(1'b0, `OFS_STATUS, 32'h300 | st_rx, 32'h387, 1'b0);
      for (i = 0; i < 3; i++) apb(1'b0, `OFS_RXFIFO, pk[i], 32'hFFFFFFFF, 1'b0);
      apb(1'b0, `OFS_STATUS, 32'h80 | st_rx, 32'h87, 1'b0);
      chip_enable <= 1'b0;
      till(1, 10);
      apb(1'b0, `OFS_STATUS, st_standby1, 32'h7, 1'b0);
      apb(1'b1, `OFS_CONTROL, 32'h0, 32'h0, 1'b0);
      apb(1'b0, `OFS_STATUS, st_power_down, 32'h7, 1'b0);
      apb(1'b0, `OFS_RADIO_SETUP, 32'h8, 32'h8, 1'b0);
      repeat (5) @(posedge pclk);
      summarize();
   end
endmodule : test_radio_mode_ctrl
bind radio_mode_ctrl radio_mode_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .chip_enable, .tx_active, .rx_active, .synth_on, .tx_pkt_start,
   .air_rate_2m);
`default_nettype wire
